// File: common/i2c_target_regs.svh
// Register offsets, field positions, reset values and timing counts of the target controller
`ifndef I2C_TARGET_REGS_SVH
`define I2C_TARGET_REGS_SVH
`define TARGET_CONTROL_OFFSET 4'h0
`define TARGET_STATUS_OFFSET 4'h1
`define TARGET_MASK_OFFSET 4'h2
`define TARGET_ADDRESS_OFFSET 4'h3
`define TARGET_EXTRA_ONE_OFFSET 4'h4
`define TARGET_EXTRA_TWO_OFFSET 4'h5
`define TARGET_EXTRA_THREE_OFFSET 4'h6
`define CTL_EXTRA_THREE_BIT 13
`define CTL_EXTRA_TWO_BIT 12
`define CTL_EXTRA_ONE_BIT 11
`define CTL_TIMEOUT_MODE_BIT 10
`define CTL_STRETCH_ENABLE_BIT 9
`define CTL_GENERAL_CALL_BIT 8
`define CTL_ACK_SELECT_BIT 5
`define CTL_STRETCH_POINT_BIT 4
`define CTL_DIRECTION_BIT 2
`define CTL_ENABLE_BIT 0
`define CTL_RESET_VALUE 16'h0001
`define CTL_WRITE_MASK 16'h3f31
`define CTL_FREE_MASK 16'h3800
`define ST_MATCH_BIT 0
`define ST_RX_BIT 1
`define ST_TX_BIT 2
`define ST_STRETCH_BIT 3
`define ST_TIMEOUT_BIT 4
`define ST_GENERAL_CALL_BIT 5
`define ST_NACK_BIT 6
`define ST_BUSY_BIT 14
`define ST_BUS_BIT 15
`define ST_FLAG_MASK 16'h007f
`define CLOCK_MHZ 250
`define TIMEOUT_MS 30
`define TIMEOUT_CYCLES (`TIMEOUT_MS * 1000 * `CLOCK_MHZ)
`endif

// File: common/i2c_target_pkg.sv
// Types shared by the target controller files
package i2c_target_pkg;
    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_ADDR = 6'h02,
        ST_ADDR_ACK = 6'h04,
        ST_RX = 6'h08,
        ST_TX = 6'h10,
        ST_DATA_ACK = 6'h20
    } phase_t;
    typedef struct packed {
        logic [3:0] addr;
        logic [15:0] wdata;
        logic write;
        logic read;
    } reg_req_t;
    typedef struct packed {
        logic scl_out;
        logic scl_oe;
        logic sda_out;
        logic sda_oe;
    } pin_drive_t;
endpackage

// File: verilog/pin_sync.sv
// Two-stage synchroniser with edge detection on the second stage output
module pin_sync (
    input wire logic clock,
    input wire logic reset,
    input wire logic pin,
    output logic level,
    output logic rise,
    output logic fall
);
    typedef struct packed {
        logic first;
        logic second;
        logic last;
    } sync_state_t;
    sync_state_t state;
    sync_state_t next_state;
    always_comb begin
        next_state = state;
        next_state.first = pin;
        next_state.second = state.first;
        next_state.last = state.second;
    end
    always_ff @(posedge clock) begin
        if (reset) begin
            state <= '{first: 1'b1, second: 1'b1, last: 1'b1};
        end else begin
            state <= next_state;
        end
    end
    assign level = state.last;
    assign rise = state.second & ~state.last;
    assign fall = ~state.second & state.last;
endmodule

// File: verilog/i2c_target.sv
// I2C/SMBus target controller with its control register, status flags and interrupt
// Behaviour
// - Each extra-address enable bit adds its extra target address to address matching.
// - The timeout mode bit enables the SMBus low-clock timeout, and disables it when clear.
// - With stretch enable set the controller holds SCL low at the selected clock; clear, never.
// - Stretch point select one stretches after the 8th falling edge, zero after the 9th.
// - Stretch point select has no effect on the bus while stretch enable is zero.
// - General call enable makes the controller answer the all-zero address.
// - While receiving, the ack cycle drives the level chosen by ack select: one NACK, zero ACK.
// - Ack select keeps its value until software changes it.
// - The direction bit takes the R/W bit after any successful address match.
// - The enable bit resets to one, all other control bits to zero.
// - Restricted bits are written only while not busy; enable writes are ignored while busy.
// - Clearing enable resets the state machine and releases SDA and SCL.
// - Busy is high while the controller takes part in a transaction.
// - With timeout mode on, SCL low for over 30 ms in a transaction flags a timeout.
// - A started stretch holds SCL low and sets the stretch flag until software clears it.
//
// Implementation choices: the address-and-strobe port and the register addresses.
`include "i2c_target_regs.svh"
module i2c_target #(
    parameter int unsigned TIMEOUT_CYCLES = `TIMEOUT_CYCLES
) (
    input wire logic clock,
    input wire logic reset,
    input wire i2c_target_pkg::reg_req_t req,
    output logic [15:0] rdata,
    input wire logic scl_in,
    input wire logic sda_in,
    output i2c_target_pkg::pin_drive_t pins,
    input wire logic [7:0] tx_data,
    output logic [7:0] rx_data,
    output logic irq
);
    typedef struct packed {
        logic [15:0] control;
        logic [6:0] flags;
        logic [6:0] mask;
        logic [6:0] own_addr;
        logic [6:0] extra_one;
        logic [6:0] extra_two;
        logic [6:0] extra_three;
        i2c_target_pkg::phase_t phase;
        logic [3:0] bit_count;
        logic [7:0] shift;
        logic [7:0] rx_data;
        logic bus_active;
        logic sda_low;
        logic stretching;
        logic [31:0] timer;
        logic [15:0] rdata;
    } target_state_t;

    target_state_t s;
    target_state_t n;
    logic scl;
    logic scl_rise;
    logic scl_fall;
    logic sda;
    logic sda_rise;
    logic sda_fall;
    logic busy;
    logic start_seen;
    logic stop_seen;
    logic [6:0] addr_in;
    logic match;
    logic general_call;
    logic enable;
    logic stretch_en;
    logic [15:0] ctl_wr;

    pin_sync scl_sync (
        .clock(clock),
        .reset(reset),
        .pin(scl_in),
        .level(scl),
        .rise(scl_rise),
        .fall(scl_fall)
    );
    pin_sync sda_sync (
        .clock(clock),
        .reset(reset),
        .pin(sda_in),
        .level(sda),
        .rise(sda_rise),
        .fall(sda_fall)
    );

    assign enable = s.control[`CTL_ENABLE_BIT];
    assign stretch_en = s.control[`CTL_STRETCH_ENABLE_BIT];
    assign start_seen = scl & sda_fall;
    assign stop_seen = scl & sda_rise;
    // Busy from address acknowledge through each byte and its ack cycle
    assign busy = (s.phase != i2c_target_pkg::ST_IDLE) && (s.phase != i2c_target_pkg::ST_ADDR);
    assign addr_in = s.shift[7:1];
    assign general_call = s.control[`CTL_GENERAL_CALL_BIT] && (s.shift == 8'h00);
    assign match = (addr_in == s.own_addr)
        || (s.control[`CTL_EXTRA_ONE_BIT] && addr_in == s.extra_one)
        || (s.control[`CTL_EXTRA_TWO_BIT] && addr_in == s.extra_two)
        || (s.control[`CTL_EXTRA_THREE_BIT] && addr_in == s.extra_three);

    always_comb begin
        n = s;
        n.rdata = 16'h0000;
        ctl_wr = s.control;
        // Busy locks all restricted bits including enable; extra-address enables stay free
        if (req.write && req.addr == `TARGET_CONTROL_OFFSET) begin
            if (busy) begin
                ctl_wr = (s.control & ~16'(`CTL_FREE_MASK)) | (req.wdata & 16'(`CTL_FREE_MASK));
            end else begin
                ctl_wr = (s.control & ~16'(`CTL_WRITE_MASK))
                    | (req.wdata & 16'(`CTL_WRITE_MASK));
            end
        end
        n.control = ctl_wr;
        n.control[`CTL_DIRECTION_BIT] = s.control[`CTL_DIRECTION_BIT];
        // Flag clear by writing one; hardware set below overrides it
        if (req.write && req.addr == `TARGET_STATUS_OFFSET) begin
            n.flags = s.flags & ~req.wdata[6:0];
        end
        if (req.write && req.addr == `TARGET_MASK_OFFSET) begin
            n.mask = req.wdata[6:0];
        end
        if (req.write && req.addr == `TARGET_ADDRESS_OFFSET) begin
            n.own_addr = req.wdata[6:0];
        end
        if (req.write && req.addr == `TARGET_EXTRA_ONE_OFFSET) begin
            n.extra_one = req.wdata[6:0];
        end
        if (req.write && req.addr == `TARGET_EXTRA_TWO_OFFSET) begin
            n.extra_two = req.wdata[6:0];
        end
        if (req.write && req.addr == `TARGET_EXTRA_THREE_OFFSET) begin
            n.extra_three = req.wdata[6:0];
        end
        if (req.read) begin
            case (req.addr)
                `TARGET_CONTROL_OFFSET: n.rdata = s.control & 16'(`CTL_WRITE_MASK | 16'h0004);
                `TARGET_STATUS_OFFSET: n.rdata = {s.bus_active, busy, 7'h00, s.flags};
                `TARGET_MASK_OFFSET: n.rdata = {9'h000, s.mask};
                `TARGET_ADDRESS_OFFSET: n.rdata = {9'h000, s.own_addr};
                `TARGET_EXTRA_ONE_OFFSET: n.rdata = {9'h000, s.extra_one};
                `TARGET_EXTRA_TWO_OFFSET: n.rdata = {9'h000, s.extra_two};
                `TARGET_EXTRA_THREE_OFFSET: n.rdata = {9'h000, s.extra_three};
                default: n.rdata = 16'h0000;
            endcase
        end

        // Stretch lasts until software clears the flag
        if (s.stretching && !n.flags[`ST_STRETCH_BIT]) begin
            n.stretching = 1'b0;
        end

        if (start_seen) begin
            n.bus_active = 1'b1;
        end else if (stop_seen) begin
            n.bus_active = 1'b0;
        end

        if (start_seen) begin
            n.phase = i2c_target_pkg::ST_ADDR;
            n.bit_count = 4'h0;
            n.sda_low = 1'b0;
        end else if (stop_seen) begin
            n.phase = i2c_target_pkg::ST_IDLE;
            n.sda_low = 1'b0;
        end else if (scl_rise) begin
            case (s.phase)
                i2c_target_pkg::ST_ADDR, i2c_target_pkg::ST_RX: begin
                    n.shift = {s.shift[6:0], sda};
                    n.bit_count = s.bit_count + 4'h1;
                end
                i2c_target_pkg::ST_TX: begin
                    n.bit_count = s.bit_count + 4'h1;
                end
                i2c_target_pkg::ST_DATA_ACK: begin
                    if (s.control[`CTL_DIRECTION_BIT]) begin
                        n.flags[`ST_TX_BIT] = 1'b1;
                        n.flags[`ST_NACK_BIT] = sda;
                        if (sda) begin
                            n.phase = i2c_target_pkg::ST_IDLE;
                        end
                    end
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            case (s.phase)
                i2c_target_pkg::ST_ADDR: begin
                    if (s.bit_count == 4'h8) begin
                        if (match || general_call) begin
                            n.phase = i2c_target_pkg::ST_ADDR_ACK;
                            n.sda_low = 1'b1;
                            n.control[`CTL_DIRECTION_BIT] = s.shift[0];
                            n.flags[`ST_MATCH_BIT] = match;
                            n.flags[`ST_GENERAL_CALL_BIT] = general_call & ~match;
                        end else begin
                            n.phase = i2c_target_pkg::ST_IDLE;
                        end
                    end
                end
                i2c_target_pkg::ST_ADDR_ACK, i2c_target_pkg::ST_DATA_ACK: begin
                    n.bit_count = 4'h0;
                    if (s.control[`CTL_DIRECTION_BIT]) begin
                        n.phase = i2c_target_pkg::ST_TX;
                        n.shift = tx_data;
                        n.sda_low = ~tx_data[7];
                    end else begin
                        n.phase = i2c_target_pkg::ST_RX;
                        n.sda_low = 1'b0;
                    end
                    // 9th falling edge stretch point
                    if (stretch_en && !s.control[`CTL_STRETCH_POINT_BIT]) begin
                        n.stretching = 1'b1;
                        n.flags[`ST_STRETCH_BIT] = 1'b1;
                    end
                end
                i2c_target_pkg::ST_RX: begin
                    if (s.bit_count == 4'h8) begin
                        n.phase = i2c_target_pkg::ST_DATA_ACK;
                        n.rx_data = s.shift;
                        n.flags[`ST_RX_BIT] = 1'b1;
                        n.sda_low = ~s.control[`CTL_ACK_SELECT_BIT];
                    end
                end
                i2c_target_pkg::ST_TX: begin
                    if (s.bit_count == 4'h8) begin
                        n.phase = i2c_target_pkg::ST_DATA_ACK;
                        n.sda_low = 1'b0;
                    end else begin
                        n.shift = {s.shift[6:0], 1'b0};
                        n.sda_low = ~s.shift[6];
                    end
                end
                default: begin
                end
            endcase
            // 8th falling edge stretch point; select ignored unless enabled
            if (stretch_en && s.control[`CTL_STRETCH_POINT_BIT] && s.bit_count == 4'h8
                && (s.phase == i2c_target_pkg::ST_RX || s.phase == i2c_target_pkg::ST_TX)) begin
                n.stretching = 1'b1;
                n.flags[`ST_STRETCH_BIT] = 1'b1;
            end
        end
        // While receiving with stretch held, ack follows the live select value
        // Only while the ack cycle lasts, so the release at its end is not undone
        if (n.phase == i2c_target_pkg::ST_DATA_ACK && !s.control[`CTL_DIRECTION_BIT]) begin
            n.sda_low = ~n.control[`CTL_ACK_SELECT_BIT];
        end

        // Timer runs while SCL low inside a transaction
        if (s.control[`CTL_TIMEOUT_MODE_BIT] && enable && !scl
            && s.phase != i2c_target_pkg::ST_IDLE) begin
            if (s.timer == TIMEOUT_CYCLES) begin
                n.flags[`ST_TIMEOUT_BIT] = 1'b1;
            end else begin
                n.timer = s.timer + 32'd1;
            end
        end else begin
            n.timer = 32'd0;
        end

        // Disabled controller forgets its transfer and lets go of both lines
        if (!enable) begin
            n.phase = i2c_target_pkg::ST_IDLE;
            n.bit_count = 4'h0;
            n.sda_low = 1'b0;
            n.stretching = 1'b0;
            n.bus_active = 1'b0;
            n.timer = 32'd0;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            s <= '0;
            s.control <= `CTL_RESET_VALUE;
            s.phase <= i2c_target_pkg::ST_IDLE;
        end else begin
            s <= n;
        end
    end

    assign rdata = s.rdata;
    assign rx_data = s.rx_data;
    assign irq = |(s.flags & s.mask);
    assign pins.scl_out = 1'b0;
    assign pins.scl_oe = s.stretching;
    assign pins.sda_out = 1'b0;
    assign pins.sda_oe = s.sda_low;
endmodule

// File: bench/i2c_target_props.sv
// Port-level assertions for the target controller
module i2c_target_props #(
    parameter int unsigned TIMEOUT_CYCLES = 50
) (
    input wire logic clock,
    input wire logic reset,
    input wire i2c_target_pkg::reg_req_t req,
    input wire logic [15:0] rdata,
    input wire logic scl_in,
    input wire logic sda_in,
    input wire i2c_target_pkg::pin_drive_t pins,
    input wire logic [7:0] tx_data,
    input wire logic [7:0] rx_data,
    input wire logic irq
);
    timeunit 1ns;
    timeprecision 100ps;
    logic touched;
    logic [6:0] mask_copy;
    logic [6:0] mask_prev;
    // Bus activity can load the direction bit, so the reset value only holds before it
    always_ff @(posedge clock) begin
        if (reset) begin
            touched <= 1'b0;
            mask_copy <= 7'h00;
            mask_prev <= 7'h00;
        end else begin
            touched <= touched | (req.write && req.addr == 4'h0) | !sda_in;
            mask_prev <= mask_copy;
            if (req.write && req.addr == 4'h2) begin
                mask_copy <= req.wdata[6:0];
            end
        end
    end
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);
    a_rdata_quiet: assert property (!$past(req.read) |-> rdata == 16'h0000)
        else $error("read data outside the answer cycle");
    a_ctl_reserved: assert property ($past(req.read && req.addr == 4'h0) |->
        (rdata & 16'hc0ca) == 16'h0000) else $error("reserved control bit reads one");
    a_ctl_reset_value: assert property ($past(req.read && req.addr == 4'h0 && !touched)
        |-> rdata == 16'h0001) else $error("control reset value wrong");
    a_unmapped_zero: assert property ($past(req.read && req.addr > 4'h6) |-> rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_open_drain: assert property (pins.scl_out == 1'b0 && pins.sda_out == 1'b0)
        else $error("line driven high");
    a_stretch_hold: assert property (pins.scl_oe && !req.write && !$past(req.write)
        && !$past(req.write, 2) |=> pins.scl_oe) else $error("stretch released alone");
    a_reset_quiet: assert property ($past(reset) |-> !pins.scl_oe && !pins.sda_oe && !irq
        && rdata == 16'h0000) else $error("outputs active after reset");
    a_irq_masked: assert property (mask_copy == 7'h00 && mask_prev == 7'h00 |-> !irq)
        else $error("interrupt with empty mask");
endmodule
bind i2c_target i2c_target_props #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) chk_u (
    .clock(clock), .reset(reset), .req(req), .rdata(rdata), .scl_in(scl_in),
    .sda_in(sda_in), .pins(pins), .tx_data(tx_data), .rx_data(rx_data), .irq(irq));

// File: bench/i2c_host.sv
// Behavioural bus host driving open-drain clock and data lines
module i2c_host (
    output logic scl_drv,
    output logic sda_drv,
    input wire logic scl_line,
    input wire logic sda_line
);
    timeunit 1ns;
    timeprecision 100ps;
    initial begin
        scl_drv = 1'b1;
        sda_drv = 1'b1;
    end
    // One high phase; waits while the target stretches, bounded so a stuck line cannot hang
    task automatic pulse(output logic s);
        int n;
        scl_drv = 1'b1;
        for (n = 0; n < 4000 && scl_line !== 1'b1; n++) #4;
        #8;
        s = sda_line;
        #8;
    endtask
    task automatic start_cond();
        logic s;
        // Step off the clock edge so line changes never race the sampling flops
        #1;
        sda_drv = 1'b1;
        #8;
        pulse(s);
        sda_drv = 1'b0;
        #16;
        scl_drv = 1'b0;
        #8;
    endtask
    // Eight bits MSB first, then a released ninth bit whose sample is the answer
    task automatic xfer_byte(input logic [7:0] out, output logic [7:0] in, output logic ack);
        for (int i = 8; i >= 0; i--) begin
            sda_drv = (i == 0) ? 1'b1 : out[i-1];
            #8;
            pulse(ack);
            if (i > 0) begin
                in[i-1] = ack;
            end
            scl_drv = 1'b0;
            #8;
        end
    endtask
    task automatic stop_cond();
        logic s;
        sda_drv = 1'b0;
        #8;
        pulse(s);
        sda_drv = 1'b1;
        #16;
    endtask
endmodule

// File: bench/tb.sv
// Self-checking bench: register access and bus transfers against the target controller
module tb;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock = 1'b0;
    logic reset = 1'b1;
    i2c_target_pkg::reg_req_t req = '0;
    logic [15:0] rdata;
    i2c_target_pkg::pin_drive_t pins;
    logic [7:0] tx_data = 8'hff;
    logic [7:0] rx_data;
    logic irq;
    logic host_scl;
    logic host_sda;
    wire logic scl_line = host_scl & ~pins.scl_oe;
    wire logic sda_line = host_sda & ~pins.sda_oe;
    int fail_count = 0;
    int checked = 0;
    int cycles = 0;
    int stretches;
    logic [15:0] v;
    logic [7:0] got;
    logic ack;
    logic done;
    logic [15:0] mctl [10] = '{16'h0001, 16'h0001, 16'h0801, 16'h0801, 16'h1001,
        16'h1001, 16'h2001, 16'h0001, 16'h0101, 16'h0000};
    logic [6:0] madr [10] = '{7'h2a, 7'h11, 7'h11, 7'h12, 7'h12, 7'h13, 7'h13, 7'h00,
        7'h00, 7'h2a};
    logic [15:0] sctl [3] = '{16'h0011, 16'h0201, 16'h0211};
    int scnt [3] = '{0, 2, 1};
    i2c_target #(.TIMEOUT_CYCLES(50)) dut_u (.clock(clock), .reset(reset), .req(req),
        .rdata(rdata), .scl_in(scl_line), .sda_in(sda_line), .pins(pins),
        .tx_data(tx_data), .rx_data(rx_data), .irq(irq));
    i2c_host host_u (.scl_drv(host_scl), .sda_drv(host_sda), .scl_line(scl_line),
        .sda_line(sda_line));
    always #2 clock = ~clock;
    task automatic close_out();
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // A hang anywhere in the bus tasks ends here instead of running forever
    always @(posedge clock) begin
        cycles++;
        if (cycles == 30000) begin
            fail_count++;
            $display("ERROR %0t run did not finish", $time);
            close_out();
        end
    end
    task automatic chk(input logic [15:0] g, input logic [15:0] e, input string what);
        checked++;
        if (g !== e) begin
            fail_count++;
            $display("ERROR %0t %s: got %h expected %h", $time, what, g, e);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clock);
        req.addr <= a;
        req.wdata <= d;
        req.write <= 1'b1;
        @(posedge clock);
        req.write <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] d);
        @(posedge clock);
        req.addr <= a;
        req.read <= 1'b1;
        @(posedge clock);
        req.read <= 1'b0;
        #1;
        d = rdata;
    endtask
    task automatic rc(input logic [3:0] a, input logic [15:0] e, input string what);
        logic [15:0] d;
        rd(a, d);
        chk(d, e, what);
    endtask
    initial begin
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        rc(4'h0, 16'h0001, "control reset");
        rc(4'hf, 16'h0000, "unmapped read");
        wr(4'h0, 16'hffff);
        rc(4'h0, 16'h3f31, "control write mask");
        wr(4'h3, 16'h002a);
        wr(4'h4, 16'h0011);
        wr(4'h5, 16'h0012);
        wr(4'h6, 16'h0013);
        $display("register test done");
        for (int k = 0; k < 10; k++) begin
            wr(4'h0, mctl[k]);
            host_u.start_cond();
            host_u.xfer_byte({madr[k], 1'b0}, got, ack);
            chk({15'h0, ack}, {15'h0, k[0]}, "address answer");
            host_u.stop_cond();
        end
        $display("address match test done");
        for (int k = 0; k < 2; k++) begin
            wr(4'h0, k[0] ? 16'h0021 : 16'h0001);
            host_u.start_cond();
            host_u.xfer_byte(8'h54, got, ack);
            rd(4'h1, v);
            chk({15'h0, v[14]}, 16'h0001, "busy in transfer");
            wr(4'h0, 16'h3800);
            rc(4'h0, k[0] ? 16'h3821 : 16'h3801, "write while busy");
            host_u.xfer_byte(8'h5a, got, ack);
            chk({15'h0, ack}, {15'h0, k[0]}, "data answer");
            chk({8'h0, rx_data}, 16'h005a, "received byte");
            host_u.stop_cond();
            rc(4'h0, k[0] ? 16'h3821 : 16'h3801, "ack select kept");
        end
        wr(4'h0, 16'h0001);
        tx_data <= 8'hc3;
        host_u.start_cond();
        host_u.xfer_byte(8'h55, got, ack);
        rc(4'h0, 16'h0005, "direction after read match");
        host_u.xfer_byte(8'hff, got, ack);
        chk({8'h0, got}, 16'h00c3, "sent byte");
        host_u.stop_cond();
        $display("transfer test done");
        wr(4'h2, 16'h0008);
        for (int k = 0; k < 3; k++) begin
            wr(4'h0, sctl[k]);
            stretches = 0;
            done = 1'b0;
            fork
                begin
                    host_u.start_cond();
                    host_u.xfer_byte(8'h54, got, ack);
                    host_u.xfer_byte(8'h33, got, ack);
                    host_u.stop_cond();
                    done = 1'b1;
                end
                while (!done) begin
                    @(posedge clock);
                    if (pins.scl_oe === 1'b1) begin
                        rd(4'h1, v);
                        chk({15'h0, v[3]}, 16'h0001, "stretch flag");
                        chk({15'h0, irq}, 16'h0001, "stretch interrupt");
                        wr(4'h1, 16'h0008);
                        stretches++;
                        repeat (8) @(posedge clock);
                    end
                end
            join
            chk(16'(stretches), 16'(scnt[k]), "stretch count");
        end
        chk({15'h0, irq}, 16'h0000, "masked flags quiet");
        $display("stretch test done");
        // Mode off first: the same long low clock must leave the flag clear
        for (int k = 0; k < 2; k++) begin
            wr(4'h1, 16'h0010);
            wr(4'h0, k[0] ? 16'h0401 : 16'h0001);
            host_u.start_cond();
            host_u.xfer_byte(8'h54, got, ack);
            repeat (80) @(posedge clock);
            rd(4'h1, v);
            chk({15'h0, v[4]}, {15'h0, k[0]}, "timeout flag");
            host_u.stop_cond();
        end
        $display("timeout test done");
        close_out();
    end
endmodule
